//--- alt_defines.svh
// register offsets, field positions and reset values of the table access block
`ifndef ALT_DEFINES_SVH
`define ALT_DEFINES_SVH
// register indices; byte address is four times the index
`define ALT_IDX_CMD      16'h1800
`define ALT_IDX_WR_LOW   16'h1801
`define ALT_IDX_WR_HIGH  16'h1802
`define ALT_IDX_RD_LOW   16'h1803
`define ALT_IDX_RD_HIGH  16'h1804
`define ALT_IDX_STATUS   16'h1805
// command bits
`define ALT_CMD_NEXT     0
`define ALT_CMD_FIRST    1
`define ALT_CMD_INSERT   2
// status bits
`define ALT_STS_PENDING  0
// high word fields
`define ALT_HI_VALID     24
`define ALT_HI_STATIC    22
`define ALT_HI_PORT_MSB  18
`define ALT_HI_PORT_LSB  16
`define ALT_HI_MASK      32'h01ffffff
`define ALT_RESET_WORD   32'h00000000
`endif

//--- alt_pkg.sv
// types of the table access block
package alt_pkg;
	typedef struct packed {
		logic [31:0] high;
		logic [31:0] low;
	} alt_entry_t;
	typedef enum logic [2:0] {
		ALT_IDLE,
		ALT_INS_SCAN,
		ALT_INS_DONE,
		ALT_RD_SCAN,
		ALT_RD_DONE
	} alt_state_t;
endpackage : alt_pkg

//--- alt_table.sv
// address lookup table with manual insert and walk commands over apb
//
// Contract
// R1 - software issues get command before reading data
// R2 - software loads write data, then inserts
// R3 - insert stores entry, device picks slot
// R4 - insert on matching address modifies/removes entry
// R5 - writing zero to command bits: no action
// R6 - software clears insert after pending clears
// R7 - pending status bit shows insert completion
// R8 - get first restarts pointer, loads first valid
// R9 - get next loads following valid entry
// R10 - software clears get bits itself
// R11 - low write word holds address bits 31:0
// R12 - low bit 0 is group address bit
// R13 - high write word holds remaining entry bits
// R14 - bit 24 valid; clear invalidates entry
// R15 - bit 22 static exempts aging/learning
// R16 - bits 18:16 select associated port
// R17 - read data stable until next get
`include "alt_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module alt_table
	import alt_pkg::*;
#(
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [17:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out
);
	localparam int IW = $clog2(DEPTH);

	// elaboration-time refusal of depths the scan counters cannot serve
	if (DEPTH < 2 || DEPTH > 1024) begin : g_depth_chk
		$error("alt_table: DEPTH out of range");
	end

	// ****************************************
	// registers
	// ****************************************
	logic [2:0]        cmd_r;
	logic [31:0]       wr_low_r;
	logic [31:0]       wr_high_r;
	alt_entry_t        rd_r;
	logic              pending_r;
	alt_state_t        state_r;
	logic [IW-1:0]     ptr_r;
	logic [IW:0]       scan_r;
	logic [IW-1:0]     free_r;
	logic              free_ok_r;
	alt_entry_t        mem_r [DEPTH];
	logic              valid_r [DEPTH];

	logic        access;
	logic        wr_en;
	logic [15:0] idx;
	logic        mapped;
	assign access = psel_in && penable_in;
	assign wr_en  = access && pwrite_in;
	assign idx    = paddr_in[17:2];
	assign mapped = (paddr_in[1:0] == 2'h0) &&
		(idx >= `ALT_IDX_CMD) && (idx <= `ALT_IDX_STATUS);

	logic insert_rise;
	logic first_rise;
	logic next_rise;
	logic cmd_wr;
	assign cmd_wr = wr_en && mapped && idx == `ALT_IDX_CMD;
	// only a 0 to 1 change starts work; zero writes do nothing
	assign insert_rise = cmd_wr && pwdata_in[`ALT_CMD_INSERT] &&
		!cmd_r[`ALT_CMD_INSERT]; // [R5]
	assign first_rise = cmd_wr && pwdata_in[`ALT_CMD_FIRST] &&
		!cmd_r[`ALT_CMD_FIRST]; // [R5]
	assign next_rise = cmd_wr && pwdata_in[`ALT_CMD_NEXT] &&
		!cmd_r[`ALT_CMD_NEXT]; // [R5]

	// ****************************************
	// apb writes
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_r     <= 3'h0;
			wr_low_r  <= `ALT_RESET_WORD;
			wr_high_r <= `ALT_RESET_WORD;
		end else if (wr_en && mapped) begin
			case (idx)
				`ALT_IDX_CMD: cmd_r <= pwdata_in[2:0]; // [R10] [R6]
				`ALT_IDX_WR_LOW: wr_low_r <= pwdata_in; // [R11] [R12]
				`ALT_IDX_WR_HIGH: begin
					wr_high_r <= pwdata_in & `ALT_HI_MASK; // [R13]
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// apb reads
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_out  <= 32'h0;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= psel_in && !pready_out;
			pslverr_out <= psel_in && !pready_out && !mapped;
			prdata_out  <= 32'h0;
			if (psel_in && !pwrite_in && mapped) begin
				case (idx)
					`ALT_IDX_CMD: prdata_out <= {29'h0, cmd_r};
					`ALT_IDX_WR_LOW: prdata_out <= wr_low_r;
					`ALT_IDX_WR_HIGH: prdata_out <= wr_high_r;
					`ALT_IDX_RD_LOW: prdata_out <= rd_r.low;
					`ALT_IDX_RD_HIGH: prdata_out <= rd_r.high;
					`ALT_IDX_STATUS: prdata_out <= {31'h0, pending_r}; // [R7]
					default: prdata_out <= 32'h0;
				endcase
			end
		end
	end

	// ****************************************
	// table engine
	// ****************************************
	logic [IW-1:0] scan_i;
	logic          hit;
	assign scan_i = scan_r[IW-1:0];
	// match on 48-bit address: low word plus high bits 15:0
	assign hit = valid_r[scan_i] && mem_r[scan_i].low == wr_low_r &&
		mem_r[scan_i].high[15:0] == wr_high_r[15:0];

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r   <= ALT_IDLE;
			pending_r <= 1'b0;
			ptr_r     <= '0;
			scan_r    <= '0;
			free_r    <= '0;
			free_ok_r <= 1'b0;
			rd_r      <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i]   <= '0;
				valid_r[i] <= 1'b0;
			end
		end else begin
			case (state_r)
				ALT_IDLE: begin
					scan_r    <= '0;
					free_ok_r <= 1'b0;
					if (insert_rise) begin
						pending_r <= 1'b1; // [R7]
						state_r   <= ALT_INS_SCAN;
					end else if (first_rise) begin
						ptr_r   <= '0; // [R8]
						state_r <= ALT_RD_SCAN;
					end else if (next_rise) begin
						scan_r  <= {1'b0, ptr_r} + 1'b1; // [R9]
						state_r <= ALT_RD_SCAN;
					end
				end
				ALT_INS_SCAN: begin
					if (scan_r == DEPTH[IW:0]) begin
						// new address: device picks first free slot
						if (free_ok_r && wr_high_r[`ALT_HI_VALID]) begin
							mem_r[free_r]   <= {wr_high_r, wr_low_r}; // [R3]
							valid_r[free_r] <= 1'b1; // [R14] [R15] [R16]
						end
						state_r <= ALT_INS_DONE;
					end else if (hit) begin
						mem_r[scan_i]   <= {wr_high_r, wr_low_r}; // [R4]
						valid_r[scan_i] <= wr_high_r[`ALT_HI_VALID]; // [R14]
						state_r         <= ALT_INS_DONE;
					end else begin
						if (!valid_r[scan_i] && !free_ok_r) begin
							free_r    <= scan_i;
							free_ok_r <= 1'b1;
						end
						scan_r <= scan_r + 1'b1;
					end
				end
				ALT_INS_DONE: begin
					pending_r <= 1'b0; // [R7]
					state_r   <= ALT_IDLE;
				end
				ALT_RD_SCAN: begin
					if (scan_r == DEPTH[IW:0]) begin
						rd_r    <= '0; // end of table reads as empty
						state_r <= ALT_RD_DONE;
					end else if (valid_r[scan_i]) begin
						rd_r    <= mem_r[scan_i]; // [R8] [R9] [R17]
						ptr_r   <= scan_i;
						state_r <= ALT_RD_DONE;
					end else begin
						scan_r <= scan_r + 1'b1;
					end
				end
				ALT_RD_DONE: state_r <= ALT_IDLE;
				default: state_r <= ALT_IDLE;
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	// cycles spent scanning for an insert
	logic [IW+1:0] ins_age_r;
	logic          new_valid;
	assign new_valid = wr_high_r[`ALT_HI_VALID];
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			ins_age_r <= '0;
		else if (state_r == ALT_INS_SCAN)
			ins_age_r <= ins_age_r + 1'b1;
		else
			ins_age_r <= '0;
	end

	pend_set_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state_r == ALT_IDLE && insert_rise |=> pending_r) // [R7]
		else $error("pending not set on insert");
	pend_clr_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state_r == ALT_INS_DONE |=> !pending_r) // [R7]
		else $error("pending not cleared on completion");
	zero_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state_r == ALT_IDLE && cmd_wr && pwdata_in[2:0] == 3'h0
		|=> state_r == ALT_IDLE) // [R5]
		else $error("zero command started work");
	rd_stable_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state_r == ALT_IDLE && !first_rise && !next_rise
		|=> $stable(rd_r)) // [R17]
		else $error("read data changed without command");
	first_ptr_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state_r == ALT_IDLE && first_rise && !insert_rise
		|=> ptr_r == '0 && scan_r == '0) // [R8]
		else $error("get first did not restart pointer");
	next_adv_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state_r == ALT_IDLE && next_rise && !insert_rise && !first_rise
		|=> scan_r == {1'b0, $past(ptr_r)} + 1'b1) // [R9]
		else $error("get next did not advance");
	ins_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state_r == ALT_INS_SCAN |-> ins_age_r <= DEPTH) // [R3]
		else $error("insert did not finish in time");
	hit_mod_a: assert property (@(posedge clk_in) disable iff (rst_in)
		state_r == ALT_INS_SCAN && scan_r != DEPTH[IW:0] && hit
		|=> valid_r[$past(scan_i)] == $past(new_valid)) // [R4]
		else $error("matching entry not modified");
	high_mask_a: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_en && mapped && idx == `ALT_IDX_WR_HIGH
		|=> wr_high_r == ($past(pwdata_in) & `ALT_HI_MASK)) // [R13]
		else $error("high write word not stored masked");
endmodule : alt_table
`default_nettype wire

//--- alt_table_tb.sv
// self-checking testbench of the table access block
`include "alt_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module alt_table_tb import alt_pkg::*;;
	logic        clk_in, rst_in, psel, penable, pwrite, pready, pslverr;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata;
	int          fails, num_checks;
	alt_entry_t  e1, e2, e3;
	localparam alt_entry_t A  = {32'h0141abcd, 32'h12345601};
	localparam alt_entry_t A2 = {32'h0140abcd, 32'h12345601};
	localparam alt_entry_t AX = {32'h0000abcd, 32'h12345601};
	localparam alt_entry_t B  = {32'h01020011, 32'h0000beef};
	localparam alt_entry_t C  = {32'h01400001, 32'hc0000001};
	localparam alt_entry_t D  = {32'h01010002, 32'hd0000002};
	localparam alt_entry_t E  = {32'h01020003, 32'he0000003};
	localparam alt_entry_t F  = {32'h01400004, 32'hf0000004};
	localparam alt_entry_t G  = {32'h00000005, 32'h70000005};
	localparam int         TB_DEPTH = 4;
	alt_table #(.DEPTH(TB_DEPTH)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr));
	// ****************************************
	// apb master and checks
	// ****************************************
	task test_done;
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk_in);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			test_done;
		end else begin
			q = prdata;
			e = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask : xfer
	task wr(input logic [15:0] idx, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, idx, d, q, e);
	endtask : wr
	task rd(input logic [15:0] idx, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic        e;
		xfer(1'b0, idx, 32'h0, q, e);
		chk(q, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask : rd
	task get(input int b, output alt_entry_t r);
		logic e;
		wr(`ALT_IDX_CMD, 32'h1 << b);
		repeat (TB_DEPTH + 3) @(posedge clk_in);
		xfer(1'b0, `ALT_IDX_RD_LOW, 32'h0, r.low, e);
		xfer(1'b0, `ALT_IDX_RD_HIGH, 32'h0, r.high, e);
		wr(`ALT_IDX_CMD, 32'h0);
	endtask : get
	task ins(input alt_entry_t v);
		logic [31:0] q;
		logic        e;
		int          n;
		wr(`ALT_IDX_WR_LOW, v.low);
		wr(`ALT_IDX_WR_HIGH, v.high);
		wr(`ALT_IDX_CMD, 32'h4);
		n = 0;
		do begin
			xfer(1'b0, `ALT_IDX_STATUS, 32'h0, q, e);
			n++;
		end while (q[`ALT_STS_PENDING] !== 1'b0 && n < 20);
		chk({31'h0, n < 20}, 32'h1);
		wr(`ALT_IDX_CMD, 32'h0);
	endtask : ins
	task pair(input alt_entry_t x, input alt_entry_t y);
		get(1, e1);
		get(0, e2);
		get(0, e3);
		chk({31'h0, (e1 === x && e2 === y) || (e1 === y && e2 === x)}, 1);
		chk(e3.low | e3.high, 32'h0);
	endtask : pair
	// ****************************************
	// scenarios
	// ****************************************
	task t_reset;
		for (int i = 0; i < 6; i++)
			rd(`ALT_IDX_CMD + 16'(i), 32'h0, 1'b0);
		$display("t_reset done");
	endtask : t_reset
	task t_walk;
		ins(A);
		ins(B);
		rd(`ALT_IDX_WR_LOW, B.low, 1'b0);
		rd(`ALT_IDX_WR_HIGH, B.high, 1'b0);
		pair(A, B);
		get(1, e3);
		chk({31'h0, e3 === e1}, 1);
		$display("t_walk done");
	endtask : t_walk
	task t_modify;
		ins(A2);
		pair(A2, B);
		ins(AX);
		get(1, e1);
		chk({31'h0, e1 === B}, 1);
		get(0, e2);
		chk(e2.low | e2.high, 32'h0);
		$display("t_modify done");
	endtask : t_modify
	task t_zero;
		get(1, e1);
		wr(`ALT_IDX_WR_LOW, A.low);
		wr(`ALT_IDX_WR_HIGH, A.high);
		wr(`ALT_IDX_CMD, 32'h0);
		wr(`ALT_IDX_CMD, 32'h0);
		repeat (TB_DEPTH + 3) @(posedge clk_in);
		rd(`ALT_IDX_RD_LOW, B.low, 1'b0);
		rd(`ALT_IDX_RD_HIGH, B.high, 1'b0);
		get(1, e1);
		get(0, e2);
		chk({31'h0, e1 === B}, 1);
		chk(e2.low | e2.high, 32'h0);
		$display("t_zero done");
	endtask : t_zero
	task t_unmapped;
		logic [31:0] q;
		logic        e;
		xfer(1'b1, 16'h1806, 32'hffffffff, q, e);
		chk({31'h0, e}, 32'h1);
		rd(16'h1806, 32'h0, 1'b1);
		rd(`ALT_IDX_RD_LOW, 32'h0, 1'b0);
		$display("t_unmapped done");
	endtask : t_unmapped
	task t_full;
		ins(G);
		ins(C);
		ins(D);
		ins(E);
		ins(F);
		get(1, e1);
		chk({31'h0, e1 === C}, 1);
		get(0, e2);
		chk({31'h0, e2 === B}, 1);
		get(0, e3);
		chk({31'h0, e3 === D}, 1);
		get(0, e1);
		chk({31'h0, e1 === E}, 1);
		get(0, e2);
		chk(e2.low | e2.high, 32'h0);
		$display("t_full done");
	endtask : t_full
	task t_rst;
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		get(1, e1);
		chk(e1.low | e1.high, 32'h0);
		rd(`ALT_IDX_WR_HIGH, 32'h0, 1'b0);
		rd(`ALT_IDX_STATUS, 32'h0, 1'b0);
		$display("t_rst done");
	endtask : t_rst
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	initial begin
		{rst_in, psel, penable, pwrite} = 4'h8;
		paddr = 18'h0;
		pwdata = 32'h0;
		fails = 0;
		num_checks = 0;
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset;
		t_walk;
		t_modify;
		t_zero;
		t_unmapped;
		t_full;
		t_rst;
		test_done;
	end
endmodule : alt_table_tb
`default_nettype wire
